/* tb/tb_usart_synchronous_mode.sv */
// Self-checking bench for the synchronous serial port.
`timescale 1ns/1ps
module tb_usart_synchronous_mode;
	import usm_pkg::*;
	logic        hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
	logic [1:0]  htrans = 2'h0;
	logic [31:0] haddr = WORD_ZERO, hwdata = WORD_ZERO, hrdata, r;
	logic        hreadyout, hresp, ck, dt, wake_req;
	usm_pin_t    clk_line, dat_line;
	int          err_total = 0, checks = 0;
	always #4 hclk = ~hclk;
	usm_top u_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
		.hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
		.hresp(hresp), .hrdata(hrdata), .clk_line_in(ck),
		.dat_line_in(dt), .clk_line(clk_line), .dat_line(dat_line),
		.wake_req(wake_req));
	usm_node u_node (.hclk(hclk), .ck_dut(clk_line), .dt_dut(dat_line),
		.ck(ck), .dt(dt));
	task automatic wrap_up;
		if (err_total == 0 && checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : wrap_up
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			err_total++;
			$display("wrong value at %0t: %h not %h", $time, seen, exp);
		end
	endtask : chk
	task automatic hang;
		err_total++;
		$display("wrong value at %0t: wait ran out", $time);
		wrap_up();
	endtask : hang
	task automatic pin(input logic seen, input logic exp);
		chk({31'h0000_0000, seen}, {31'h0000_0000, exp});
	endtask : pin
	task automatic edge_rdy;
		int n;
		n = 0;
		do begin
			@(posedge hclk);
			n++;
		end while (hreadyout !== 1'b1 && n < 64);
		if (n >= 64)
			hang();
	endtask : edge_rdy
	task automatic bus(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		hsel <= 1'b1;
		htrans <= HT_NONSEQ;
		haddr <= {24'h00_0000, a};
		hwrite <= w;
		edge_rdy();
		htrans <= 2'h0;
		hsel <= 1'b0;
		hwdata <= w ? d : WORD_ZERO;
		edge_rdy();
		r = hrdata;
	endtask : bus
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		bus(1'b1, a, d);
		repeat (2) @(posedge hclk);
	endtask : wr
	task automatic rdc(input logic [7:0] a, input logic [31:0] e);
		bus(1'b0, a, WORD_ZERO);
		chk(r, e);
	endtask : rdc
	task automatic poll(input logic [7:0] a, input logic [31:0] m);
		int n;
		n = 0;
		do begin
			bus(1'b0, a, WORD_ZERO);
			n++;
		end while ((r & m) !== m && n < 400);
		if (n >= 400)
			hang();
		@(posedge hclk);
	endtask : poll
	task automatic take(input logic [7:0] e);
		logic [7:0] b;
		int n;
		n = 0;
		while (u_node.seen.size() < 8 && n < 4000) begin
			@(posedge hclk);
			n++;
		end
		if (n >= 4000)
			hang();
		for (int i = 0; i < 8; i++)
			b[i] = u_node.seen.pop_front();
		chk({24'h00_0000, b}, {24'h00_0000, e});
	endtask : take
	initial begin
		// The node holds the clock line low whenever the device lets go.
		u_node.pulses(0);
		repeat (10) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		rdc(OFF_TXCTL, 32'h0000_0002);
		rdc(OFF_RXCTL, WORD_ZERO);
		wr(8'h20, 32'h0000_00FF);
		rdc(8'h20, WORD_ZERO);
		wr(OFF_BAUD, 32'h0000_0003);
		wr(OFF_RXCTL, 32'h0000_0080);
		wr(OFF_TXCTL, 32'h0000_00A0);
		pin(clk_line.oe, 1'b0);
		wr(OFF_TXCTL, 32'h0000_00B0);
		pin(clk_line.oe, 1'b1);
		rdc(OFF_FLAGS, 32'h0000_0001);
		u_node.seen.delete();
		bus(1'b1, OFF_TXBUF, 32'h0000_00A5);
		bus(1'b1, OFF_TXBUF, 32'h0000_003C);
		rdc(OFF_TXCTL, 32'h0000_00B0);
		rdc(OFF_FLAGS, WORD_ZERO);
		take(8'hA5);
		take(8'h3C);
		poll(OFF_TXCTL, 32'h0000_0002);
		rdc(OFF_FLAGS, 32'h0000_0001);
		bus(1'b1, OFF_TXBUF, 32'h0000_00FF);
		wr(OFF_TXCTL, 32'h0000_0090);
		pin(clk_line.oe, 1'b0);
		pin(dat_line.oe, 1'b0);
		rdc(OFF_TXCTL, 32'h0000_0092);
		wr(OFF_TXCTL, 32'h0000_00B0);
		u_node.seen.delete();
		u_node.serve(8'h5A);
		bus(1'b1, OFF_TXBUF, 32'h0000_000F);
		wr(OFF_RXCTL, 32'h0000_00A0);
		pin(dat_line.oe, 1'b0);
		pin(clk_line.oe, 1'b1);
		poll(OFF_FLAGS, 32'h0000_0002);
		rdc(OFF_RXCTL, 32'h0000_0080);
		rdc(OFF_RXBUF, 32'h0000_005A);
		pin(dat_line.oe, 1'b1);
		poll(OFF_TXCTL, 32'h0000_0002);
		chk(32'(u_node.seen.size()), 32'h0000_0008);
		wr(OFF_TXCTL, 32'h0000_0090);
		wr(OFF_FLAGS, 32'h0000_0020);
		u_node.serve(8'hC3);
		wr(OFF_RXCTL, 32'h0000_00B0);
		poll(OFF_FLAGS, 32'h0000_0002);
		pin(wake_req, 1'b1);
		rdc(OFF_RXCTL, 32'h0000_00B0);
		rdc(OFF_RXBUF, 32'h0000_00C3);
		wr(OFF_RXCTL, 32'h0000_0080);
		bus(1'b0, OFF_RXBUF, WORD_ZERO);
		wr(OFF_TXCTL, 32'h0000_0030);
		pin(clk_line.oe, 1'b0);
		wr(OFF_FLAGS, 32'h0000_0010);
		u_node.seen.delete();
		bus(1'b1, OFF_TXBUF, 32'h0000_0081);
		wr(OFF_TXBUF, 32'h0000_007E);
		rdc(OFF_FLAGS, 32'h0000_0010);
		pin(wake_req, 1'b0);
		u_node.pulses(8);
		take(8'h81);
		poll(OFF_FLAGS, 32'h0000_0001);
		pin(wake_req, 1'b1);
		u_node.pulses(8);
		take(8'h7E);
		wr(OFF_RXCTL, WORD_ZERO);
		pin(dat_line.oe, 1'b0);
		wrap_up();
	end
endmodule : tb_usart_synchronous_mode

/* tb/usm_node.sv */
// Far-side serial node: slave clock, word source and bit capture.
`timescale 1ns/1ps
module usm_node
	import usm_pkg::*;
(
	input  wire logic          hclk,
	input  wire usm_pkg::usm_pin_t ck_dut,
	input  wire usm_pkg::usm_pin_t dt_dut,
	output logic               ck,
	output logic               dt
);
	import usm_pkg::*;
	logic       ck_q = 1'b0, ck_oe = 1'b0, ck_l = 1'b0, dt_l = 1'b0;
	logic       dt_oe = 1'b0, fell = 1'b0, armed = 1'b0, d_oe_q = 1'b0;
	logic [7:0] word = 8'h00;
	int         idx = 0;
	logic       seen[$];
	// A released line shows the inverse of its last level, never a copy.
	assign ck = ck_dut.oe ? ck_dut.drv : ck_oe ? ck_q : ~ck_l;
	assign dt = dt_dut.oe ? dt_dut.drv : dt_oe ? word[idx] : ~dt_l;
	always @(posedge hclk) begin
		if (ck_dut.oe || ck_oe)
			ck_l <= ck;
		if (dt_dut.oe || dt_oe)
			dt_l <= dt;
		d_oe_q <= dt_dut.oe;
		if (armed && !dt_dut.oe && !dt_oe) begin
			dt_oe <= 1'b1;
			idx <= 0;
			fell <= 1'b0;
			armed <= 1'b0;
		end
	end
	// Bits move on at rises so each is settled at the sampling fall.
	always @(posedge ck) begin
		if (dt_oe && fell && idx == 7)
			dt_oe <= 1'b0;
		else if (dt_oe && fell)
			idx <= idx + 1;
	end
	always @(negedge ck) begin
		// A fall in the cycle the device takes the line is not a data bit.
		if (dt_dut.oe && d_oe_q)
			seen.push_back(dt);
		if (dt_oe && !dt_dut.oe)
			fell <= 1'b1;
	end
	task automatic pulses(input int n);
		ck_oe = 1'b1;
		repeat (n) begin
			#32 ck_q = 1'b1;
			#32 ck_q = 1'b0;
		end
	endtask : pulses
	task automatic serve(input logic [7:0] w);
		word = w;
		armed = 1'b1;
	endtask : serve
endmodule : usm_node

/* verilog/usm_pkg.sv */
// Register map, field positions and carrier types of the serial port.
// Contract
// RULE_01: Transmit and receive never run together.
// RULE_02: Mode select bit four enables synchronous.
// RULE_03: Port enable hands both pins over.
// RULE_04: Clock source set: device drives clock; the code drives it only while transmit enable is set or a receive is active.
// RULE_05: Data changes at rise, stable at fall.
// RULE_06: Clearing transmit enable aborts, resets, floats pins.
// RULE_07: Receive enable aborts transmit, floats data.
// RULE_08: Receive abort keeps transmitter state intact.
// RULE_09: Single receive clears itself, transmit resumes.
// RULE_10: Software clears transmit enable before single.
// RULE_11: Either receive enable starts master reception.
// RULE_12: Receive samples data at falling clock.
// RULE_13: Single takes one word, continuous streams.
// RULE_14: Both enables set behaves as continuous.
// RULE_15: Each word sets receive flag, gated wake.
// RULE_16: Slave uses external clock, shifts asleep.
// RULE_17: Second queued word waits, flag stays clear.
// RULE_18: Second word loads after first, may wake.
// RULE_19: Master transmit setup order by software.
// RULE_20: Master receive starts with enables clear.
// RULE_21: Slave transmit setup order by software.
// RULE_22: Software clears errors via continuous enable.
// RULE_23: Transmit flag means enabled and buffer empty.
// RULE_24: Port disable holds all state in reset.
// RULE_25: Idle status clears on load, sets after.
// RULE_26: Least significant bit first, ninth bit last.
package usm_pkg;
	localparam logic [7:0] OFF_RXCTL = 8'h00;
	localparam logic [7:0] OFF_TXCTL = 8'h04;
	localparam logic [7:0] OFF_BAUD  = 8'h08;
	localparam logic [7:0] OFF_TXBUF = 8'h0C;
	localparam logic [7:0] OFF_RXBUF = 8'h10;
	localparam logic [7:0] OFF_FLAGS = 8'h14;
	localparam int RX_SERIAL_PORT_ENABLE  = 7;
	localparam int RX_RX9   = 6;
	localparam int RX_SINGLE_RECEIVE_ENABLE  = 5;
	localparam int RX_CONTINUOUS_RECEIVE_ENABLE  = 4;
	localparam int RX_ADDRESS_DETECT_ENABLE = 3;
	localparam int RX_OERR  = 1;
	localparam int RX_NINTH = 0;
	localparam int TX_CLOCK_SOURCE_MASTER  = 7;
	localparam int TX_TX9   = 6;
	localparam int TX_TRANSMIT_ENABLE  = 5;
	localparam int TX_SYNC  = 4;
	localparam int TX_IDLE  = 1;
	localparam int TX_NINTH = 0;
	localparam int FL_TRANSMIT_BUFFER_EMPTY_FLAG  = 0;
	localparam int FL_RECEIVE_FULL_FLAG  = 1;
	localparam int FL_TRANSMIT_INTERRUPT_ENABLE  = 4;
	localparam int FL_RECEIVE_INTERRUPT_ENABLE  = 5;
	localparam int NINTH    = 8;
	localparam logic [3:0] LAST8 = 4'h7;
	localparam logic [3:0] LAST9 = 4'h8;
	localparam logic [1:0] HT_NONSEQ = 2'h2;
	localparam logic [31:0] WORD_ZERO = 32'h0000_0000;
	typedef enum {ST_IDLE, ST_TX, ST_RX} usm_state_t;
	typedef struct packed {
		logic drv;
		logic oe;
	} usm_pin_t;
endpackage : usm_pkg

/* verilog/usm_top.sv */
`timescale 1ns/1ps
// Synchronous serial port with AHB-Lite registers and shared pin drive.
module usm_top #(
	parameter int unsigned DIV_W = 8
) (
	input  wire logic              hclk,
	input  wire logic              hresetn,
	input  wire logic              hsel,
	input  wire logic [31:0]       haddr,
	input  wire logic [1:0]        htrans,
	input  wire logic              hwrite,
	input  wire logic [2:0]        hsize,
	input  wire logic [31:0]       hwdata,
	input  wire logic              hready,
	output logic                   hreadyout,
	output logic                   hresp,
	output logic [31:0]            hrdata,
	input  wire logic              clk_line_in,
	input  wire logic              dat_line_in,
	output usm_pkg::usm_pin_t      clk_line,
	output usm_pkg::usm_pin_t      dat_line,
	output logic                   wake_req
);
	import usm_pkg::*;

	logic             serial_port_enable_q, rx9_q, single_receive_enable_q, continuous_receive_enable_q, address_detect_enable_q, oerr_q;
	logic             clock_source_master_q, tx9_q, transmit_enable_q, sync_q, transmit_ninth_bit_q;
	logic             transmit_interrupt_enable_q, receive_interrupt_enable_q;
	logic [DIV_W-1:0] baud_q, div_q;
	logic             mclk_q;
	logic [8:0]       txbuf_q, tsr_q, rsr_q, receive_buffer_q, rx_word;
	logic             buf_full_q, tsr_full_q, receive_full_flag_q;
	logic [3:0]       tx_cnt_q, rx_cnt_q, tx_last, rx_last;
	logic             ck_s1_q, ck_s2_q, ck_s3_q, dt_s1_q, dt_s2_q;
	usm_state_t       state_q, state_d;
	logic [31:0]      hrdata_q, rd_word;
	logic             hreadyout_q, wake_q;
	usm_pin_t         clk_line_q, dat_line_q;
	logic             wr_pend_q;
	logic [7:0]       wr_addr_q;
	logic             port_on, rx_act, tx_mode, transmit_buffer_empty_flag, run, tick;
	logic             rise_ev, fall_ev, rx_done, tx_fall, tx_done;
	logic             load, acc, rd_rxbuf, wr_rx, wr_tx, wr_txbuf;

	assign hreadyout = hreadyout_q;
	assign hresp     = 1'b0;
	assign hrdata    = hrdata_q;
	assign clk_line  = clk_line_q;
	assign dat_line  = dat_line_q;
	assign wake_req  = wake_q;

	// Bus decode: zero wait states, so every transfer finishes in one cycle.
	assign acc      = hsel & hready & (htrans == HT_NONSEQ);
	assign rd_rxbuf = acc & ~hwrite & (haddr[7:0] == OFF_RXBUF);
	assign wr_rx    = wr_pend_q & (wr_addr_q == OFF_RXCTL);
	assign wr_tx    = wr_pend_q & (wr_addr_q == OFF_TXCTL);
	assign wr_txbuf = wr_pend_q & (wr_addr_q == OFF_TXBUF);

	assign port_on = serial_port_enable_q & sync_q; // RULE_02 RULE_03
	// Single receive matters only with our own clock; continuous wins.
	assign rx_act  = port_on & (continuous_receive_enable_q | (clock_source_master_q & single_receive_enable_q)); // RULE_11 RULE_14
	assign tx_mode = port_on & transmit_enable_q & ~rx_act; // RULE_01 RULE_07
	assign transmit_buffer_empty_flag    = port_on & transmit_enable_q & ~buf_full_q; // RULE_23
	assign tx_last = tx9_q ? LAST9 : LAST8;
	assign rx_last = rx9_q ? LAST9 : LAST8;

	// The master clock only runs while there is work, and always parks low.
	assign run  = port_on & clock_source_master_q & (rx_act | (tx_mode & tsr_full_q));
	assign tick = (div_q == baud_q);
	always_comb begin
		if (clock_source_master_q) begin // RULE_04
			rise_ev = tick & ~mclk_q & run;
			fall_ev = tick & mclk_q;
		end else begin // RULE_16
			rise_ev = ck_s2_q & ~ck_s3_q;
			fall_ev = ~ck_s2_q & ck_s3_q;
		end
	end

	assign load    = port_on & transmit_enable_q & buf_full_q & ~tsr_full_q;
	assign tx_fall = tx_mode & tsr_full_q & fall_ev;
	assign tx_done = tx_fall & (tx_cnt_q == tx_last);
	assign rx_done = rx_act & fall_ev & (rx_cnt_q == rx_last);

	always_comb begin
		rx_word = rsr_q;
		rx_word[rx_cnt_q] = dt_s2_q; // RULE_12 RULE_26
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ck_s1_q <= 1'b0;
			ck_s2_q <= 1'b0;
			ck_s3_q <= 1'b0;
			dt_s1_q <= 1'b0;
			dt_s2_q <= 1'b0;
		end else begin
			ck_s1_q <= clk_line_in;
			ck_s2_q <= ck_s1_q;
			ck_s3_q <= ck_s2_q;
			dt_s1_q <= dat_line_in;
			dt_s2_q <= dt_s1_q;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			div_q  <= '0;
			mclk_q <= 1'b0;
		end else if (!run && !mclk_q) begin
			div_q <= '0;
		end else if (tick) begin
			div_q  <= '0;
			mclk_q <= ~mclk_q;
		end else begin
			div_q <= div_q + 1'b1;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend_q <= 1'b0;
			wr_addr_q <= 8'h00;
		end else begin
			wr_pend_q <= acc & hwrite;
			wr_addr_q <= haddr[7:0];
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			serial_port_enable_q  <= 1'b0;
			rx9_q   <= 1'b0;
			single_receive_enable_q  <= 1'b0;
			continuous_receive_enable_q  <= 1'b0;
			address_detect_enable_q <= 1'b0;
			clock_source_master_q  <= 1'b0;
			tx9_q   <= 1'b0;
			transmit_enable_q  <= 1'b0;
			sync_q  <= 1'b0;
			transmit_ninth_bit_q  <= 1'b0;
			baud_q  <= '0;
			transmit_interrupt_enable_q  <= 1'b0;
			receive_interrupt_enable_q  <= 1'b0;
		end else begin
			if (rx_done && !continuous_receive_enable_q)
				single_receive_enable_q <= 1'b0; // RULE_09 RULE_13
			if (wr_rx) begin
				serial_port_enable_q  <= hwdata[RX_SERIAL_PORT_ENABLE];
				rx9_q   <= hwdata[RX_RX9];
				single_receive_enable_q  <= hwdata[RX_SINGLE_RECEIVE_ENABLE];
				continuous_receive_enable_q  <= hwdata[RX_CONTINUOUS_RECEIVE_ENABLE];
				address_detect_enable_q <= hwdata[RX_ADDRESS_DETECT_ENABLE];
			end
			if (wr_tx) begin
				clock_source_master_q <= hwdata[TX_CLOCK_SOURCE_MASTER];
				tx9_q  <= hwdata[TX_TX9];
				transmit_enable_q <= hwdata[TX_TRANSMIT_ENABLE];
				sync_q <= hwdata[TX_SYNC];
				transmit_ninth_bit_q <= hwdata[TX_NINTH];
			end
			if (wr_pend_q && wr_addr_q == OFF_BAUD)
				baud_q <= hwdata[DIV_W-1:0];
			if (wr_pend_q && wr_addr_q == OFF_FLAGS) begin
				transmit_interrupt_enable_q <= hwdata[FL_TRANSMIT_INTERRUPT_ENABLE];
				receive_interrupt_enable_q <= hwdata[FL_RECEIVE_INTERRUPT_ENABLE];
			end
		end
	end

	// Transmit buffer and shifter; a receive pause freezes, never clears.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			txbuf_q    <= '0;
			buf_full_q <= 1'b0;
			tsr_q      <= '0;
			tsr_full_q <= 1'b0;
			tx_cnt_q   <= 4'h0;
		end else if (!serial_port_enable_q) begin // RULE_24
			buf_full_q <= 1'b0;
			tsr_full_q <= 1'b0;
			tx_cnt_q   <= 4'h0;
		end else begin
			if (!transmit_enable_q || !port_on) begin // RULE_06
				tsr_full_q <= 1'b0;
				tx_cnt_q   <= 4'h0;
			end else if (load) begin // RULE_17 RULE_18 RULE_25
				tsr_q      <= tx9_q ? txbuf_q : {1'b0, txbuf_q[7:0]};
				tsr_full_q <= 1'b1;
				tx_cnt_q   <= 4'h0;
			end else if (tx_done) begin // RULE_25
				tsr_full_q <= 1'b0;
				tx_cnt_q   <= 4'h0;
			end else if (tx_fall) begin // RULE_08 RULE_26
				tsr_q    <= tsr_q >> 1;
				tx_cnt_q <= tx_cnt_q + 4'h1;
			end
			if (load)
				buf_full_q <= 1'b0;
			if (wr_txbuf) begin // RULE_23
				txbuf_q    <= {transmit_ninth_bit_q, hwdata[7:0]};
				buf_full_q <= 1'b1;
			end
		end
	end

	// Receive shifter; a word landing on a full buffer is lost, flagged as overrun only under continuous receive.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			rsr_q    <= '0;
			rx_cnt_q <= 4'h0;
			receive_buffer_q  <= '0;
			receive_full_flag_q   <= 1'b0;
			oerr_q   <= 1'b0;
		end else if (!port_on) begin // RULE_24
			rx_cnt_q <= 4'h0;
			receive_full_flag_q   <= 1'b0;
			oerr_q   <= 1'b0;
		end else begin
			if (!rx_act)
				rx_cnt_q <= 4'h0;
			else if (rx_done)
				rx_cnt_q <= 4'h0;
			else if (fall_ev) begin // RULE_12
				rsr_q    <= rx_word;
				rx_cnt_q <= rx_cnt_q + 4'h1;
			end
			if (rx_done && !oerr_q && (!receive_full_flag_q || rd_rxbuf)) begin
				receive_buffer_q <= rx9_q ? rx_word : {1'b0, rx_word[7:0]};
				receive_full_flag_q  <= 1'b1; // RULE_15
			end else if (rd_rxbuf)
				receive_full_flag_q <= 1'b0;
			if (!continuous_receive_enable_q)
				oerr_q <= 1'b0; // RULE_22
			else if (rx_done && receive_full_flag_q && !rd_rxbuf)
				oerr_q <= 1'b1;
		end
	end

	always_comb begin
		state_d = state_q;
		case (state_q)
			ST_IDLE: begin
				if (rx_act)
					state_d = ST_RX;
				else if (tx_mode)
					state_d = ST_TX;
			end
			ST_TX: begin
				if (rx_act)
					state_d = ST_RX; // RULE_07
				else if (!tx_mode)
					state_d = ST_IDLE;
			end
			ST_RX: begin
				if (!rx_act)
					state_d = tx_mode ? ST_TX : ST_IDLE; // RULE_09
			end
			default: state_d = ST_IDLE;
		endcase
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state_q    <= ST_IDLE;
			clk_line_q <= '0;
			dat_line_q <= '0;
			wake_q     <= 1'b0;
		end else begin
			state_q        <= state_d;
			dat_line_q.oe  <= (state_d == ST_TX); // RULE_01 RULE_06
			clk_line_q.oe  <= port_on & clock_source_master_q & (transmit_enable_q | rx_act); // RULE_04
			clk_line_q.drv <= mclk_q;
			if (rise_ev && tx_mode && tsr_full_q)
				dat_line_q.drv <= tsr_q[0]; // RULE_05
			wake_q <= (transmit_buffer_empty_flag & transmit_interrupt_enable_q) | (receive_full_flag_q & receive_interrupt_enable_q); // RULE_15 RULE_18
		end
	end

	always_comb begin
		rd_word = WORD_ZERO;
		if (haddr[7:0] == OFF_RXCTL) begin
			rd_word[RX_SERIAL_PORT_ENABLE]  = serial_port_enable_q;
			rd_word[RX_RX9]   = rx9_q;
			rd_word[RX_SINGLE_RECEIVE_ENABLE]  = single_receive_enable_q;
			rd_word[RX_CONTINUOUS_RECEIVE_ENABLE]  = continuous_receive_enable_q;
			rd_word[RX_ADDRESS_DETECT_ENABLE] = address_detect_enable_q;
			rd_word[RX_OERR]  = oerr_q;
			rd_word[RX_NINTH] = receive_buffer_q[NINTH];
		end else if (haddr[7:0] == OFF_TXCTL) begin
			rd_word[TX_CLOCK_SOURCE_MASTER]  = clock_source_master_q;
			rd_word[TX_TX9]   = tx9_q;
			rd_word[TX_TRANSMIT_ENABLE]  = transmit_enable_q;
			rd_word[TX_SYNC]  = sync_q;
			rd_word[TX_IDLE]  = ~tsr_full_q; // RULE_25
			rd_word[TX_NINTH] = transmit_ninth_bit_q;
		end else if (haddr[7:0] == OFF_BAUD) begin
			rd_word[DIV_W-1:0] = baud_q;
		end else if (haddr[7:0] == OFF_RXBUF) begin
			rd_word[7:0] = receive_buffer_q[7:0];
		end else if (haddr[7:0] == OFF_FLAGS) begin
			rd_word[FL_TRANSMIT_BUFFER_EMPTY_FLAG] = transmit_buffer_empty_flag;
			rd_word[FL_RECEIVE_FULL_FLAG] = receive_full_flag_q;
			rd_word[FL_TRANSMIT_INTERRUPT_ENABLE] = transmit_interrupt_enable_q;
			rd_word[FL_RECEIVE_INTERRUPT_ENABLE] = receive_interrupt_enable_q;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata_q    <= WORD_ZERO;
			hreadyout_q <= 1'b1;
		end else if (acc && !hwrite) begin
			hrdata_q <= rd_word;
		end
	end

	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);

	sequence s_word_in;
		rx_done && !oerr_q && !receive_full_flag_q;
	endsequence
	sequence s_flag_up;
		##1 receive_full_flag_q ##1 receive_buffer_q[0] == $past(rx_word[0], 2);
	endsequence

	a_half_duplex: assert property ( // RULE_01
		!(dat_line_q.oe && rx_act && $past(rx_act)))
		else $error("data driven while receiving");
	a_transmit_enable_float: assert property ( // RULE_06
		!transmit_enable_q |=> !dat_line_q.oe ##0 !tsr_full_q)
		else $error("transmit enable clear did not float data");
	a_rx_abort: assert property ( // RULE_07
		rx_act && clock_source_master_q |=> !dat_line_q.oe && clk_line_q.oe)
		else $error("receive did not float data or lost clock");
	a_slave_clk: assert property ( // RULE_16
		!clock_source_master_q |=> !clk_line_q.oe)
		else $error("slave drives clock");
	a_rx_flag: assert property ( // RULE_15
		s_word_in |-> s_flag_up)
		else $error("received word not posted");
	a_single_clr: assert property ( // RULE_13
		rx_done && !continuous_receive_enable_q && !wr_rx |=> !single_receive_enable_q)
		else $error("single receive not cleared");
	a_transmit_buffer_empty_flag_write: assert property ( // RULE_23
		wr_txbuf && serial_port_enable_q |=> !transmit_buffer_empty_flag)
		else $error("transmit flag set with full buffer");
	a_idle_load: assert property ( // RULE_25
		load |=> tsr_full_q)
		else $error("idle status did not clear on load");
	a_serial_port_enable_reset: assert property ( // RULE_24
		!serial_port_enable_q |=> !tsr_full_q && !receive_full_flag_q && !buf_full_q)
		else $error("port disable did not reset state");
	a_wake_gate: assert property ( // RULE_15
		receive_full_flag_q && !receive_interrupt_enable_q && !(transmit_buffer_empty_flag && transmit_interrupt_enable_q) |=> !wake_q)
		else $error("wake raised with enables clear");
endmodule : usm_top
